/* File: src/vectored_interrupt_trap_unit.sv */
// vectored interrupt, event transfer and trap unit
//
// Behaviour
// - thirty-two nodes, each assignable to any of sixteen priority levels
// - accepted interrupt saves pointer and status, segment too when seg_mode is set, then branches
// - event transfer moves one byte or word in segment 0 via one of eight channels
// - event transfer stalls the CPU one cycle and saves no status
// - transfers use the same arbitration but only the two top levels
// - falling non-maskable pin raises a trap regardless of interrupt enables
// - hardware traps beat all requests, act at once, save status
// - software trap vector comes from a seven-bit trap number
// - each node holds request flag, enable bit and priority setting
// - several source events may drive one node; cause stays in the source
// - subnodes share one node under the subnode control register
// - own vector per node; all class B traps share one vector plus flags
// - vector address is trap number times four
// - vector table sits at the bottom of code segment 0
// - software setting a request flag acts like a hardware request
// - at cycle end best request served only above CPU priority
// - flag cleared on service; kept set when transfer count hits zero
// - flags set even when disabled; only enabled nodes arbitrate
`timescale 1ns/1ps
`default_nettype none
module vectored_interrupt_trap_unit
	import irq_trap_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [DATA_W-1:0] reg_rdata,
	input wire logic [NODES-1:0] src_event,
	input wire logic [SUBS-1:0] sub_event,
	input wire logic instr_cycle_end,
	input wire logic cpu_ien,
	input wire logic [3:0] cpu_level,
	input wire logic seg_mode,
	input wire logic nmi_pin_b,
	input wire logic stack_ovf,
	input wire logic stack_unf,
	input wire logic [4:0] class_b_event,
	input wire logic sw_trap_req,
	input wire logic [6:0] sw_trap_num,
	output logic branch_go,
	output logic [8:0] branch_vector,
	output logic save_status,
	output logic save_segment,
	output logic stall_cycle,
	output logic xfer_go,
	output logic [15:0] xfer_src,
	output logic [15:0] xfer_dst,
	output logic xfer_byte,
	output logic irq
);

	typedef struct packed {
		node_s [NODES-1:0] node;
		chan_s [CHANS-1:0] chan;
		logic [CHANS-1:0][15:0] src;
		logic [CHANS-1:0][15:0] dst;
		logic [SUBS-1:0] sub_en;
		logic [SUBS-1:0] sub_req;
		logic [15:0] trap_cause_flags;
		logic [3:0] trap_pend;
		logic [3:0] irq_stat;
		logic [3:0] irq_mask;
		logic nmi_low;
		logic [15:0] rdata;
		logic branch_go;
		logic [8:0] branch_vector;
		logic save_status;
		logic save_segment;
		logic stall_cycle;
		logic xfer_go;
		logic [15:0] xfer_src;
		logic [15:0] xfer_dst;
		logic xfer_byte;
	} state_s;

	state_s st_ff;
	state_s nxt_st;

	arb_if arb ();

	priority_resolver u_resolver (
		.arb(arb)
	);

	// only enabled nodes with a raised flag compete
	always_comb begin
		for (int i = 0; i < NODES; i++) begin
			arb.req[i] = st_ff.node[i].request_flag & st_ff.node[i].node_enable_flag;
			arb.lvl[i] = st_ff.node[i].priority_level_field;
			arb.grp[i] = st_ff.node[i].group_level_field;
		end
	end

	always_comb begin
		logic nmi_edge;
		logic sub_hit;
		logic [15:0] tf_set;
		logic [3:0] tp_set;
		logic [3:0] ev;
		logic [NODES-1:0] node_ev;
		logic [2:0] ch;
		logic [7:0] cnt_left;
		logic [15:0] step;
		logic [2:0] idx3;
		nxt_st = st_ff;
		nmi_edge = 1'b0;
		sub_hit = 1'b0;
		tf_set = 16'h0000;
		tp_set = 4'h0;
		ev = 4'h0;
		node_ev = src_event;
		ch = 3'h0;
		cnt_left = 8'h00;
		step = STEP_WORD;
		idx3 = reg_addr[2:0];

		// one-cycle outputs
		nxt_st.rdata = 16'h0000;
		nxt_st.branch_go = 1'b0;
		nxt_st.save_status = 1'b0;
		nxt_st.save_segment = 1'b0;
		nxt_st.stall_cycle = 1'b0;
		nxt_st.xfer_go = 1'b0;

		// trap detection
		nmi_edge = !nmi_pin_b && !st_ff.nmi_low;
		nxt_st.nmi_low = !nmi_pin_b;
		tf_set[TF_NMI] = nmi_edge;
		tf_set[TF_STKOF] = stack_ovf;
		tf_set[TF_STKUF] = stack_unf;
		tf_set[TF_UNDOPC] = class_b_event[4];
		tf_set[TF_PRTFLT] = class_b_event[3];
		tf_set[TF_ILLOPA] = class_b_event[2];
		tf_set[TF_ILLINA] = class_b_event[1];
		tf_set[TF_ILLBUS] = class_b_event[0];
		tp_set[TP_NMI] = nmi_edge;
		tp_set[TP_STKOF] = stack_ovf;
		tp_set[TP_STKUF] = stack_unf;
		tp_set[TP_CLASS_B] = |class_b_event;

		// subnodes feed one shared node
		sub_hit = |(sub_event & st_ff.sub_en);
		node_ev[SUBNODE_NODE] = src_event[SUBNODE_NODE] | sub_hit;

		// register writes
		if (reg_wr) begin
			if (reg_addr < A_CHAN_CTRL) begin
				nxt_st.node[reg_addr[4:0]] = node_s'(reg_wdata[7:0]);
			end else if (reg_addr < A_CHAN_SRC) begin
				nxt_st.chan[idx3] = chan_s'(reg_wdata[10:0]);
			end else if (reg_addr < A_CHAN_DST) begin
				nxt_st.src[idx3] = reg_wdata;
			end else if (reg_addr < A_SUBNODE) begin
				nxt_st.dst[idx3] = reg_wdata;
			end else if (reg_addr == A_SUBNODE) begin
				nxt_st.sub_en = reg_wdata[7:0];
				nxt_st.sub_req = reg_wdata[15:8];
			end else if (reg_addr == A_TRAP_FLAGS) begin
				nxt_st.trap_cause_flags = reg_wdata & TF_IMPL;
			end else if (reg_addr == A_IRQ_MASK) begin
				nxt_st.irq_mask = reg_wdata[3:0];
			end
		end

		// register reads, data one cycle later
		if (reg_rd) begin
			if (reg_addr < A_CHAN_CTRL) begin
				nxt_st.rdata = {8'h00, st_ff.node[reg_addr[4:0]]};
			end else if (reg_addr < A_CHAN_SRC) begin
				nxt_st.rdata = {5'h00, st_ff.chan[idx3]};
			end else if (reg_addr < A_CHAN_DST) begin
				nxt_st.rdata = st_ff.src[idx3];
			end else if (reg_addr < A_SUBNODE) begin
				nxt_st.rdata = st_ff.dst[idx3];
			end else if (reg_addr == A_SUBNODE) begin
				nxt_st.rdata = {st_ff.sub_req, st_ff.sub_en};
			end else if (reg_addr == A_TRAP_FLAGS) begin
				nxt_st.rdata = st_ff.trap_cause_flags;
			end else if (reg_addr == A_IRQ_STAT) begin
				nxt_st.rdata = {12'h000, st_ff.irq_stat};
				nxt_st.irq_stat = 4'h0;
			end else if (reg_addr == A_IRQ_MASK) begin
				nxt_st.rdata = {12'h000, st_ff.irq_mask};
			end
		end

		// service: hardware traps, software trap, then arbitrated requests
		if (|st_ff.trap_pend) begin
			nxt_st.branch_go = 1'b1;
			nxt_st.save_status = 1'b1;
			nxt_st.save_segment = seg_mode;
			ev[EV_TRAP] = 1'b1;
			if (st_ff.trap_pend[TP_NMI]) begin
				nxt_st.branch_vector = {TN_NMI, VEC_ENTRY_ZEROS};
				nxt_st.trap_pend[TP_NMI] = 1'b0;
			end else if (st_ff.trap_pend[TP_STKOF]) begin
				nxt_st.branch_vector = {TN_STKOF, VEC_ENTRY_ZEROS};
				nxt_st.trap_pend[TP_STKOF] = 1'b0;
			end else if (st_ff.trap_pend[TP_STKUF]) begin
				nxt_st.branch_vector = {TN_STKUF, VEC_ENTRY_ZEROS};
				nxt_st.trap_pend[TP_STKUF] = 1'b0;
			end else begin
				nxt_st.branch_vector = {TN_CLASS_B, VEC_ENTRY_ZEROS};
				nxt_st.trap_pend[TP_CLASS_B] = 1'b0;
			end
		end else if (sw_trap_req) begin
			nxt_st.branch_go = 1'b1;
			nxt_st.save_status = 1'b1;
			nxt_st.save_segment = seg_mode;
			nxt_st.branch_vector = {sw_trap_num, VEC_ENTRY_ZEROS};
			ev[EV_TRAP] = 1'b1;
		end else if (instr_cycle_end && cpu_ien && arb.win_valid && arb.win_lvl > cpu_level) begin
			ch = {arb.win_lvl[0], st_ff.node[arb.win_idx].group_level_field};
			if (arb.win_lvl >= XFER_MIN_LVL && st_ff.chan[ch].count != 8'h00) begin
				step = st_ff.chan[ch].byte_mode ? STEP_BYTE : STEP_WORD;
				cnt_left = st_ff.chan[ch].count - 8'h01;
				nxt_st.xfer_go = 1'b1;
				nxt_st.stall_cycle = 1'b1;
				nxt_st.xfer_src = st_ff.src[ch];
				nxt_st.xfer_dst = st_ff.dst[ch];
				nxt_st.xfer_byte = st_ff.chan[ch].byte_mode;
				nxt_st.chan[ch].count = cnt_left;
				unique case (st_ff.chan[ch].inc)
					INC_DST: nxt_st.dst[ch] = st_ff.dst[ch] + step;
					INC_SRC: nxt_st.src[ch] = st_ff.src[ch] + step;
					INC_NONE: ;
					default: ;
				endcase
				ev[EV_XFER] = 1'b1;
				if (cnt_left != 8'h00) begin
					nxt_st.node[arb.win_idx].request_flag = 1'b0;
				end else begin
					ev[EV_CNT_ZERO] = 1'b1;
				end
			end else begin
				nxt_st.branch_go = 1'b1;
				nxt_st.save_status = 1'b1;
				nxt_st.save_segment = seg_mode;
				nxt_st.branch_vector = {NODE_TRAP_BASE + 7'(arb.win_idx), VEC_ENTRY_ZEROS};
				nxt_st.node[arb.win_idx].request_flag = 1'b0;
				ev[EV_BRANCH] = 1'b1;
			end
		end

		// hardware sets last so they win over any clear
		for (int i = 0; i < NODES; i++) begin
			if (node_ev[i]) begin
				nxt_st.node[i].request_flag = 1'b1;
			end
		end
		nxt_st.sub_req = nxt_st.sub_req | sub_event;
		nxt_st.trap_cause_flags = nxt_st.trap_cause_flags | tf_set;
		nxt_st.trap_pend = nxt_st.trap_pend | tp_set;
		nxt_st.irq_stat = nxt_st.irq_stat | ev;
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign reg_rdata = st_ff.rdata;
	assign branch_go = st_ff.branch_go;
	assign branch_vector = st_ff.branch_vector;
	assign save_status = st_ff.save_status;
	assign save_segment = st_ff.save_segment;
	assign stall_cycle = st_ff.stall_cycle;
	assign xfer_go = st_ff.xfer_go;
	assign xfer_src = st_ff.xfer_src;
	assign xfer_dst = st_ff.xfer_dst;
	assign xfer_byte = st_ff.xfer_byte;
	assign irq = |(st_ff.irq_stat & st_ff.irq_mask);

endmodule : vectored_interrupt_trap_unit
`default_nettype wire

/* File: shared/irq_trap_pkg.sv */
// constants and types shared by the interrupt and trap unit
package irq_trap_pkg;

	localparam int NODES = 32;
	localparam int CHANS = 8;
	localparam int SUBS = 8;

	// register port
	localparam int ADDR_W = 6;
	localparam int DATA_W = 16;
	localparam logic [5:0] A_NODE_BASE = 6'h00;
	localparam logic [5:0] A_CHAN_CTRL = 6'h20;
	localparam logic [5:0] A_CHAN_SRC = 6'h28;
	localparam logic [5:0] A_CHAN_DST = 6'h30;
	localparam logic [5:0] A_SUBNODE = 6'h38;
	localparam logic [5:0] A_TRAP_FLAGS = 6'h39;
	localparam logic [5:0] A_IRQ_STAT = 6'h3a;
	localparam logic [5:0] A_IRQ_MASK = 6'h3b;

	// trap numbers; the vector is the trap number times four
	localparam logic [6:0] TN_NMI = 7'h02;
	localparam logic [6:0] TN_STKOF = 7'h04;
	localparam logic [6:0] TN_STKUF = 7'h06;
	localparam logic [6:0] TN_CLASS_B = 7'h0a;
	localparam logic [6:0] NODE_TRAP_BASE = 7'h18;
	localparam logic [1:0] VEC_ENTRY_ZEROS = 2'h0;

	// node shared by the subnodes
	localparam logic [4:0] SUBNODE_NODE = 5'h1f;

	// levels reserved for event transfers
	localparam logic [3:0] XFER_MIN_LVL = 4'he;

	// trap cause flag positions
	localparam int TF_NMI = 15;
	localparam int TF_STKOF = 14;
	localparam int TF_STKUF = 13;
	localparam int TF_UNDOPC = 7;
	localparam int TF_PRTFLT = 3;
	localparam int TF_ILLOPA = 2;
	localparam int TF_ILLINA = 1;
	localparam int TF_ILLBUS = 0;
	localparam logic [15:0] TF_IMPL = 16'he08f;

	// pending trap positions
	localparam int TP_NMI = 0;
	localparam int TP_STKOF = 1;
	localparam int TP_STKUF = 2;
	localparam int TP_CLASS_B = 3;

	// interrupt status positions
	localparam int EV_TRAP = 0;
	localparam int EV_BRANCH = 1;
	localparam int EV_XFER = 2;
	localparam int EV_CNT_ZERO = 3;

	// pointer steps
	localparam logic [15:0] STEP_BYTE = 16'h0001;
	localparam logic [15:0] STEP_WORD = 16'h0002;

	typedef enum logic [1:0] {
		INC_NONE = 2'b00,
		INC_DST = 2'b01,
		INC_SRC = 2'b10
	} inc_mode_e;

	typedef struct packed {
		logic request_flag;
		logic node_enable_flag;
		logic [3:0] priority_level_field;
		logic [1:0] group_level_field;
	} node_s;

	typedef struct packed {
		inc_mode_e inc;
		logic byte_mode;
		logic [7:0] count;
	} chan_s;

endpackage : irq_trap_pkg

/* File: shared/arb_if.sv */
// request and winner signals between the unit and its priority resolver
`timescale 1ns/1ps
`default_nettype none
interface arb_if;
	import irq_trap_pkg::*;
	logic [NODES-1:0] req;
	logic [NODES-1:0][3:0] lvl;
	logic [NODES-1:0][1:0] grp;
	logic win_valid;
	logic [4:0] win_idx;
	logic [3:0] win_lvl;
	modport requester(output req, output lvl, output grp, input win_valid, input win_idx, input win_lvl);
	modport resolver(input req, input lvl, input grp, output win_valid, output win_idx, output win_lvl);
endinterface : arb_if
`default_nettype wire

/* File: src/priority_resolver.sv */
// picks the highest priority enabled request among all nodes
`timescale 1ns/1ps
`default_nettype none
module priority_resolver
	import irq_trap_pkg::*;
(
	arb_if.resolver arb
);
	always_comb begin
		logic found;
		logic [4:0] idx;
		logic [5:0] key;
		found = 1'b0;
		idx = 5'h00;
		key = 6'h00;
		for (int i = 0; i < NODES; i++) begin
			// level first, group second, lower index on a full tie
			if (arb.req[i] && (!found || {arb.lvl[i], arb.grp[i]} > key)) begin
				found = 1'b1;
				idx = 5'(i);
				key = {arb.lvl[i], arb.grp[i]};
			end
		end
		arb.win_valid = found;
		arb.win_idx = idx;
		arb.win_lvl = key[5:2];
	end
endmodule : priority_resolver
`default_nettype wire

/* File: verif/vectored_interrupt_trap_unit_asserts.sv */
// port assertions for the interrupt and trap unit
`timescale 1ns/1ps
`default_nettype none
module vectored_interrupt_trap_unit_asserts
	import irq_trap_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic reg_rd,
	input wire logic [DATA_W-1:0] reg_rdata,
	input wire logic seg_mode,
	input wire logic nmi_pin_b,
	input wire logic stack_ovf,
	input wire logic branch_go,
	input wire logic [8:0] branch_vector,
	input wire logic save_status,
	input wire logic save_segment,
	input wire logic stall_cycle,
	input wire logic xfer_go
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	a_branch_saves_state: assert property (branch_go |-> save_status && save_segment == $past(seg_mode))
		else $error("branch without status save");
	a_save_only_branch: assert property ((save_status || save_segment) |-> branch_go)
		else $error("status saved without branch");
	a_stall_one_cycle: assert property ((xfer_go || stall_cycle) |-> (xfer_go && stall_cycle) ##1 !stall_cycle)
		else $error("transfer stall not single");
	a_one_service: assert property (!(branch_go && xfer_go))
		else $error("branch and transfer together");
	a_vector_aligned: assert property (branch_go |-> branch_vector[1:0] == VEC_ENTRY_ZEROS)
		else $error("vector not four byte aligned");
	a_nmi_react: assert property ($fell(nmi_pin_b) |-> ##2 branch_go && branch_vector == {TN_NMI, VEC_ENTRY_ZEROS})
		else $error("nmi trap missing");
	a_stack_trap: assert property (stack_ovf && nmi_pin_b |-> ##2 branch_go)
		else $error("stack trap late");
	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0)
		else $error("read data outside read slot");
	c_xfer: cover property (xfer_go);
	c_seg_branch: cover property (branch_go && save_segment);
	c_nmi: cover property ($fell(nmi_pin_b));
endmodule : vectored_interrupt_trap_unit_asserts
`default_nettype wire

/* File: verif/cpu_model.sv */
// cpu side model: instruction cycle ends, held back during a transfer stall
`timescale 1ns/1ps
`default_nettype none
module cpu_model (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic stall_cycle,
	output logic instr_cycle_end
);
	logic phase_ff;
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			phase_ff <= 1'h0;
		end else if (!stall_cycle) begin
			phase_ff <= !phase_ff;
		end
	end
	assign instr_cycle_end = phase_ff && !stall_cycle;
endmodule : cpu_model
`default_nettype wire

/* File: verif/vectored_interrupt_trap_unit_bench.sv */
// self-checking bench for the interrupt and trap unit
`timescale 1ns/1ps
`default_nettype none
module vectored_interrupt_trap_unit_bench
	import irq_trap_pkg::*;
;
	logic core_clk, rst_b, reg_wr, reg_rd, cpu_ien, seg_mode, nmi_pin_b, stack_ovf, stack_unf, sw_trap_req;
	logic instr_cycle_end, branch_go, save_status, save_segment, stall_cycle, xfer_go, xfer_byte, irq;
	logic [5:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata, xfer_src, xfer_dst;
	logic [31:0] src_event;
	logic [7:0] sub_event;
	logic [3:0] cpu_level;
	logic [4:0] class_b_event;
	logic [6:0] sw_trap_num;
	logic [8:0] branch_vector;
	int err_total, comparisons, cycles;
	vectored_interrupt_trap_unit i_vectored_interrupt_trap_unit (.core_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .src_event, .sub_event, .instr_cycle_end, .cpu_ien, .cpu_level, .seg_mode, .nmi_pin_b,
		.stack_ovf, .stack_unf, .class_b_event, .sw_trap_req, .sw_trap_num, .branch_go, .branch_vector, .save_status,
		.save_segment, .stall_cycle, .xfer_go, .xfer_src, .xfer_dst, .xfer_byte, .irq);
	cpu_model i_cpu_model (.core_clk, .rst_b, .stall_cycle, .instr_cycle_end);
	always #20 core_clk = !core_clk;
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : print_verdict
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 4000) begin
			err_total++;
			print_verdict();
		end
	end
	task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task automatic wr(input logic [5:0] a, input logic [15:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(posedge core_clk);
		reg_wr <= 1'h0;
		@(posedge core_clk);
	endtask : wr
	task automatic rd(input logic [5:0] a, input logic [15:0] exp);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge core_clk);
		reg_rd <= 1'h0;
		@(posedge core_clk);
		check("reg_rdata", reg_rdata, exp);
	endtask : rd
	task automatic svc(input logic eb, input logic ex, input logic [6:0] tn);
		int n;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (!(branch_go || xfer_go) && n < 30);
		check("branch_go", 16'(branch_go), 16'(eb));
		check("xfer_go", 16'(xfer_go), 16'(ex));
		check("save_status", 16'(save_status), 16'(eb));
		check("save_segment", 16'(save_segment), 16'(eb & seg_mode));
		check("stall_cycle", 16'(stall_cycle), 16'(ex));
		if (eb) check("branch_vector", 16'(branch_vector), 16'({tn, 2'h0}));
	endtask : svc
	task automatic pulse(input int n);
		src_event[n] <= 1'h1;
		@(posedge core_clk);
		src_event <= 32'h0;
	endtask : pulse
	initial begin
		core_clk = 1'h0;
		rst_b = 1'h0;
		{reg_wr, reg_rd, stack_ovf, stack_unf, sw_trap_req} = 5'h0;
		{reg_addr, reg_wdata, src_event, sub_event, class_b_event, sw_trap_num} = 74'h0;
		{cpu_ien, seg_mode, nmi_pin_b, cpu_level} = 7'h71;
		repeat (12) @(posedge core_clk);
		rst_b <= 1'h1;
		@(posedge core_clk);
		wr(A_NODE_BASE + 6'h05, 16'h004c);
		pulse(5);
		svc(1'h1, 1'h0, NODE_TRAP_BASE + 7'h05);
		rd(A_NODE_BASE + 6'h05, 16'h004c);
		wr(A_NODE_BASE + 6'h06, 16'h000c);
		pulse(6);
		svc(1'h0, 1'h0, 7'h0);
		rd(A_NODE_BASE + 6'h06, 16'h008c);
		wr(A_NODE_BASE + 6'h07, 16'h00cc);
		svc(1'h1, 1'h0, NODE_TRAP_BASE + 7'h07);
		cpu_level <= 4'h6;
		wr(A_NODE_BASE + 6'h0a, 16'h00d9);
		wr(A_NODE_BASE + 6'h0b, 16'h00db);
		svc(1'h0, 1'h0, 7'h0);
		cpu_level <= 4'h5;
		svc(1'h1, 1'h0, NODE_TRAP_BASE + 7'h0b);
		svc(1'h1, 1'h0, NODE_TRAP_BASE + 7'h0a);
		$display("interrupt tests done");
		rd(A_IRQ_STAT, 16'h0002);
		wr(A_IRQ_MASK, 16'h0008);
		wr(A_CHAN_CTRL, 16'h0002);
		wr(A_CHAN_SRC, 16'h0100);
		wr(A_CHAN_DST, 16'h0200);
		wr(A_NODE_BASE + 6'h09, 16'h0078);
		pulse(9);
		svc(1'h0, 1'h1, 7'h0);
		check("xfer_src", xfer_src, 16'h0100);
		check("xfer_dst", xfer_dst, 16'h0200);
		check("xfer_byte", 16'(xfer_byte), 16'h0);
		rd(A_NODE_BASE + 6'h09, 16'h0078);
		rd(A_CHAN_CTRL, 16'h0001);
		wr(A_CHAN_CTRL, 16'h0303);
		pulse(9);
		svc(1'h0, 1'h1, 7'h0);
		check("xfer_byte", 16'(xfer_byte), 16'h1);
		check("xfer_dst", xfer_dst, 16'h0200);
		rd(A_CHAN_DST, 16'h0201);
		wr(A_CHAN_CTRL, 16'h0401);
		pulse(9);
		svc(1'h0, 1'h1, 7'h0);
		svc(1'h1, 1'h0, NODE_TRAP_BASE + 7'h09);
		check("irq", 16'(irq), 16'h1);
		rd(A_IRQ_STAT, 16'h000e);
		check("irq", 16'(irq), 16'h0);
		rd(A_CHAN_SRC, 16'h0102);
		$display("transfer test done");
		{cpu_ien, seg_mode} <= 2'h0;
		nmi_pin_b <= 1'h0;
		svc(1'h1, 1'h0, TN_NMI);
		nmi_pin_b <= 1'h1;
		stack_ovf <= 1'h1;
		@(posedge core_clk);
		stack_ovf <= 1'h0;
		svc(1'h1, 1'h0, TN_STKOF);
		for (int i = 0; i < 5; i++) begin
			class_b_event <= 5'h1 << i;
			@(posedge core_clk);
			class_b_event <= 5'h0;
			svc(1'h1, 1'h0, TN_CLASS_B);
		end
		rd(A_TRAP_FLAGS, 16'hc08f);
		check("irq", 16'(irq), 16'h0);
		stack_unf <= 1'h1;
		@(posedge core_clk);
		stack_unf <= 1'h0;
		svc(1'h1, 1'h0, TN_STKUF);
		sw_trap_num <= 7'h7f;
		sw_trap_req <= 1'h1;
		@(posedge core_clk);
		sw_trap_req <= 1'h0;
		svc(1'h1, 1'h0, 7'h7f);
		rd(A_TRAP_FLAGS, 16'he08f);
		wr(A_TRAP_FLAGS, 16'h0000);
		rd(A_TRAP_FLAGS, 16'h0000);
		$display("trap tests done");
		wr(A_SUBNODE, 16'h0001);
		wr(A_NODE_BASE + 6'h1f, 16'h005c);
		sub_event <= 8'h01;
		@(posedge core_clk);
		sub_event <= 8'h00;
		svc(1'h0, 1'h0, 7'h0);
		cpu_ien <= 1'h1;
		svc(1'h1, 1'h0, NODE_TRAP_BASE + 7'h1f);
		rd(A_SUBNODE, 16'h0101);
		rd(6'h3c, 16'h0000);
		$display("subnode test done");
		print_verdict();
	end
endmodule : vectored_interrupt_trap_unit_bench
bind vectored_interrupt_trap_unit vectored_interrupt_trap_unit_asserts i_asserts (.core_clk, .rst_b, .reg_rd,
	.reg_rdata, .seg_mode, .nmi_pin_b, .stack_ovf, .branch_go, .branch_vector, .save_status, .save_segment,
	.stall_cycle, .xfer_go);
`default_nettype wire
